/* core/pbc_consts.svh */
// register offsets, field positions, reset values and counts of the loop control
`ifndef PBC_CONSTS_SVH
`define PBC_CONSTS_SVH

// word addresses on the register bus
`define PBC_ADDR_CTRL     2'h0
`define PBC_ADDR_BW       2'h1
`define PBC_ADDR_PROG     2'h2

// loop control register bits
`define PBC_B_IE          7
`define PBC_B_FLAG        6
`define PBC_B_PON         5
`define PBC_B_BCS         4
`define PBC_CTRL_LOW_RD   4'hf

// bandwidth control register bits
`define PBC_B_AUTO        7
`define PBC_B_LOCK        6
`define PBC_B_ACQ         5
`define PBC_B_XLD         4
`define PBC_BW_LOW_RD     4'h0

// multiplier programming register fields
`define PBC_MUL_HI        7
`define PBC_MUL_LO        4
`define PBC_VRS_HI        3
`define PBC_VRS_LO        0

// reset values
`define PBC_MUL_RST       4'h6
`define PBC_VRS_RST       4'h6
`define PBC_PON_RST       1'b1
`define PBC_ZERO4         4'h0
`define PBC_ONE4          4'h1

// reference-loss window is this many cycles per unit of multiplier
`define PBC_XLD_CYC_PER_N 6'h04
`define PBC_XLD_CNT_W     6

`endif

/* core/pbc_loop_ctrl.sv */
// loop bandwidth, multiplier and lock-interrupt control with avalon slave
`timescale 1ns/1ps
`include "pbc_consts.svh"

module pbc_loop_ctrl
  import pbc_pkg::*;
(
  input  wire logic        mclk,                    // bus clock
  input  wire logic        sys_rst,                 // sync reset
  input  wire logic [1:0]  avs_address,             // word address
  input  wire logic        avs_read,                // read request
  input  wire logic        avs_write,               // write request
  input  wire logic [31:0] avs_writedata,           // write data
  output logic      [31:0] avs_readdata,            // read data
  output logic             avs_waitrequest,         // stall
  input  wire logic        lock_raw,                // analog lock level
  input  wire logic        track_raw,               // analog tracking level
  input  wire logic        ref_active_raw,          // crystal activity
  input  wire logic        break_state,             // debug break active
  input  wire logic        break_flag_clear_enable, // clear allowed in break
  output logic             loop_irq_line,           // cpu request
  output logic             loop_enable,             // analog loop on
  output logic             base_clock_source_sel,   // vco drives base clock
  output logic             auto_bw,                 // automatic bandwidth
  output logic             capture_phase_n,         // manual phase force
  output logic      [3:0]  feedback_n,              // divider modulus
  output logic      [3:0]  vco_range_sel            // vco range field
);

  // synchronised analog levels
  logic [2:0]  sync_out;
  logic        lock_s;            // settled frequency
  logic        track_s;           // tracking phase
  logic        ref_s;             // reference active

  // bus handshake
  pbc_bus_st_t st_q, st_d;
  logic        wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic        take;              // request accepted this cycle

  // control state
  logic        auto_q, auto_d;    // automatic bandwidth
  logic        acq_man_q, acq_man_d;  // manual capture phase
  logic        ie_q, ie_d;        // interrupt enable
  logic        flag_q, flag_d;    // interrupt flag
  logic        pon_q, pon_d;      // loop power on
  logic        bcs_q, bcs_d;      // base clock source select
  logic [3:0]  mul_q, mul_d;      // multiplier field
  logic [3:0]  vrs_q, vrs_d;      // range field
  logic        lock_dly_q;        // delayed lock copy
  logic        irq_q, irq_d;      // registered request
  logic        en_q, en_d;        // registered loop enable
  logic [3:0]  fbn_q, fbn_d;      // registered modulus

  // reference-loss check
  logic        xld_q, xld_d;      // loss result
  logic        xbusy_q, xbusy_d;  // window open
  logic        xseen_q, xseen_d;  // activity seen in window
  logic [`PBC_XLD_CNT_W-1:0] xcnt_q, xcnt_d;

  // decoded read views and helpers
  logic [7:0]  rd_ctrl;
  logic [7:0]  rd_bw;
  logic [7:0]  rd_prog;
  logic [3:0]  n_map;             // effective modulus
  logic        lock_chg;          // lock toggled
  logic        rd_clr;            // flag clear by read
  logic        wr_ctrl;
  logic        wr_bw;
  logic        wr_prog;

  // bring analog levels into the bus clock
  pbc_sync3 #(
    .W (3)
  ) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .din     ({lock_raw, track_raw, ref_active_raw}),
    .dout    (sync_out)
  );

  assign lock_s  = sync_out[2];
  assign track_s = sync_out[1];
  assign ref_s   = sync_out[0];

  assign n_map = (mul_q == `PBC_ZERO4) ? `PBC_ONE4 : mul_q;

  assign lock_chg = auto_q & (lock_s != lock_dly_q);

  // read views of the three registers
  always_comb begin
    // flag and enable hidden in manual
    rd_ctrl = {ie_q & auto_q, flag_q & auto_q, pon_q, bcs_q,
               `PBC_CTRL_LOW_RD};
    rd_bw = {auto_q, lock_s & auto_q, auto_q ? track_s : acq_man_q,
             bcs_q & xld_q, `PBC_BW_LOW_RD};
    rd_prog = {mul_q, vrs_q};
  end

  // request decode; actions happen when the request is taken
  assign take    = (st_q == pbc_idle) & (avs_read | avs_write);
  assign wr_ctrl = take & avs_write & (avs_address == `PBC_ADDR_CTRL);
  assign wr_bw   = take & avs_write & (avs_address == `PBC_ADDR_BW);
  assign wr_prog = take & avs_write & (avs_address == `PBC_ADDR_PROG);
  assign rd_clr  = take & avs_read & (avs_address == `PBC_ADDR_CTRL) &
                   ~(break_state & ~break_flag_clear_enable);

  // next values of bus, control and loss-window state; the ack state touches only the handshake
  // no wait input: bus, lock, reference activity and the loss window move state
  always_comb begin
    st_d      = st_q;
    wait_d    = wait_q;
    rdata_d   = rdata_q;
    auto_d    = auto_q;
    acq_man_d = acq_man_q;
    ie_d      = ie_q;
    flag_d    = flag_q;
    pon_d     = pon_q;
    bcs_d     = bcs_q;
    mul_d     = mul_q;
    vrs_d     = vrs_q;
    xld_d     = xld_q;
    xbusy_d   = xbusy_q;
    xseen_d   = xseen_q;
    xcnt_d    = xcnt_q;

    // bus handshake: one wait cycle, then a single answer cycle
    case (st_q)
      pbc_idle: begin
        if (avs_read | avs_write) begin
          st_d   = pbc_ack;
          wait_d = 1'b0;
          if (avs_read) begin
            case (avs_address)
              `PBC_ADDR_CTRL: rdata_d = {24'h000000, rd_ctrl};
              `PBC_ADDR_BW:   rdata_d = {24'h000000, rd_bw};
              `PBC_ADDR_PROG: rdata_d = {24'h000000, rd_prog};
              default:        rdata_d = 32'h00000000;
            endcase
          end
        end
      end
      pbc_ack: begin
        st_d   = pbc_idle;
        wait_d = 1'b1;
      end
      default: begin
        st_d   = pbc_idle;
        wait_d = 1'b1;
      end
    endcase

    // loop control register write
    if (wr_ctrl) begin
      // enable is writable only in auto
      ie_d  = auto_q & avs_writedata[`PBC_B_IE];
      pon_d = avs_writedata[`PBC_B_PON] | bcs_q;
      bcs_d = avs_writedata[`PBC_B_BCS] & pon_q & (vrs_q != `PBC_ZERO4);
    end

    // bandwidth control register write; low test bits are dropped
    if (wr_bw) begin
      auto_d = avs_writedata[`PBC_B_AUTO];
      if (!auto_q) begin
        acq_man_d = avs_writedata[`PBC_B_ACQ];
      end
    end

    // programming register write
    if (wr_prog) begin
      if (!pon_q) begin
        mul_d = avs_writedata[`PBC_MUL_HI:`PBC_MUL_LO];
        vrs_d = avs_writedata[`PBC_VRS_HI:`PBC_VRS_LO];
      end
    end

    if (!pon_q || (vrs_q == `PBC_ZERO4)) begin
      bcs_d = 1'b0;
    end

    // enable forced low in manual
    if (!auto_q) begin
      ie_d = 1'b0;
    end

    if (lock_chg) begin
      flag_d = 1'b1;
    end else if (rd_clr) begin
      flag_d = 1'b0;
    end
    if (!auto_q) begin
      flag_d = 1'b0;
    end

    if (xbusy_q) begin
      xseen_d = xseen_q | ref_s;
      xcnt_d  = xcnt_q - `PBC_XLD_CNT_W'(1);
      if (xcnt_q == `PBC_XLD_CNT_W'(1)) begin
        xbusy_d = 1'b0;
        xld_d   = ~(xseen_q | ref_s);
      end
    end
    if (wr_bw && avs_writedata[`PBC_B_XLD] && bcs_q) begin
      xld_d   = 1'b1;
      xbusy_d = 1'b1;
      xseen_d = 1'b0;
      xcnt_d  = {2'b00, n_map} * `PBC_XLD_CYC_PER_N;
    end
    if (!bcs_q) begin
      xld_d   = 1'b0;
      xbusy_d = 1'b0;
    end
  end

  // registered outputs
  always_comb begin
    irq_d = flag_q & ie_q & auto_q;
    en_d  = pon_d & (vrs_d != `PBC_ZERO4);
    fbn_d = (mul_d == `PBC_ZERO4) ? `PBC_ONE4 : mul_d;
  end

  // register every state group
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q       <= pbc_idle;
      wait_q     <= 1'b1;
      rdata_q    <= 32'h00000000;
      auto_q     <= 1'b0;
      acq_man_q  <= 1'b0;
      ie_q       <= 1'b0;
      flag_q     <= 1'b0;
      pon_q      <= `PBC_PON_RST;
      bcs_q      <= 1'b0;
      mul_q      <= `PBC_MUL_RST;
      vrs_q      <= `PBC_VRS_RST;
      lock_dly_q <= 1'b0;
      irq_q      <= 1'b0;
      en_q       <= `PBC_PON_RST;
      fbn_q      <= `PBC_MUL_RST;
      xld_q      <= 1'b0;
      xbusy_q    <= 1'b0;
      xseen_q    <= 1'b0;
      xcnt_q     <= '0;
    end else begin
      st_q       <= st_d;
      wait_q     <= wait_d;
      rdata_q    <= rdata_d;
      auto_q     <= auto_d;
      acq_man_q  <= acq_man_d;
      ie_q       <= ie_d;
      flag_q     <= flag_d;
      pon_q      <= pon_d;
      bcs_q      <= bcs_d;
      mul_q      <= mul_d;
      vrs_q      <= vrs_d;
      lock_dly_q <= lock_s;
      irq_q      <= irq_d;
      en_q       <= en_d;
      fbn_q      <= fbn_d;
      xld_q      <= xld_d;
      xbusy_q    <= xbusy_d;
      xseen_q    <= xseen_d;
      xcnt_q     <= xcnt_d;
    end
  end

  // drive ports from flops
  assign avs_readdata          = rdata_q;
  assign avs_waitrequest       = wait_q;
  assign loop_irq_line         = irq_q;
  assign loop_enable           = en_q;
  assign base_clock_source_sel = bcs_q;
  assign auto_bw               = auto_q;
  assign capture_phase_n       = acq_man_q;
  assign feedback_n            = fbn_q;
  assign vco_range_sel         = vrs_q;

  // checks on the control logic
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_bw_reset: assert property (
    $past(sys_rst) |-> (!auto_q && !flag_q && !bcs_q && pon_q))
    else $error("state wrong after reset");

  chk_lock_manual: assert property (
    (take && avs_read && (avs_address == 2'h1) && !auto_q)
      |=> !avs_readdata[`PBC_B_LOCK])
    else $error("lock visible in manual mode");

  chk_acq_hold: assert property (
    (auto_q && $past(auto_q)) |-> $stable(acq_man_q))
    else $error("manual phase store changed in auto");

  chk_xld_off: assert property (
    !bcs_q |=> (!xld_q && !xbusy_q))
    else $error("loss bit set without vco select");

  chk_n_zero: assert property (
    ((mul_q == 4'h0) && $stable(mul_q)) |=> (feedback_n == 4'h1))
    else $error("zero multiplier not mapped to one");

  chk_mul_lock: assert property (
    pon_q |=> (mul_q == $past(mul_q)))
    else $error("multiplier changed while loop on");

  chk_vrs_lock: assert property (
    pon_q |=> (vrs_q == $past(vrs_q)))
    else $error("range changed while loop on");

  chk_vrs_zero_bcs: assert property (
    (vrs_q == 4'h0) |-> (!bcs_q && !loop_enable))
    else $error("select or loop on with zero range");

  chk_flag_set: assert property (
    (auto_q && (lock_s != lock_dly_q) && $stable(auto_q))
      |=> (flag_q || !auto_q))
    else $error("lock change did not set flag");

  chk_flag_manual: assert property (
    !auto_q |=> (!loop_irq_line && !rd_ctrl[`PBC_B_FLAG]))
    else $error("irq or flag active in manual mode");

  chk_break_keep: assert property (
    (take && avs_read && (avs_address == 2'h0) && break_state &&
     !break_flag_clear_enable && flag_q && auto_q && auto_d) |=> flag_q)
    else $error("flag cleared in protected break");

  chk_pon_hold: assert property (
    bcs_q |=> pon_q)
    else $error("power dropped while selected");

  chk_bus_answer: assert property (
    take |=> (!avs_waitrequest ##1 avs_waitrequest))
    else $error("bus answer not one cycle after take");

  cov_lock_irq: cover property (auto_q && ie_q && lock_chg ##2 loop_irq_line);
  cov_xld_done: cover property (xbusy_q ##1 !xbusy_q && bcs_q);
  cov_bcs_set:  cover property (!bcs_q ##1 bcs_q);
  cov_brk_read: cover property (rd_clr && break_state);

endmodule // pbc_loop_ctrl

/* core/pbc_pkg.sv */
// types shared by the loop control block
package pbc_pkg;

  // bus slave handshake states
  typedef enum logic {
    pbc_idle,
    pbc_ack
  } pbc_bus_st_t;

endpackage

/* core/pbc_sync3.sv */
// three-stage input synchroniser with agreement filter, one per bit
`timescale 1ns/1ps
`include "pbc_consts.svh"

module pbc_sync3
  import pbc_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  genvar gi;

  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic s1_q;   // first stage, read only by s2
      logic s2_q;   // second stage
      logic s3_q;   // third stage
      logic o_q;    // accepted level
      logic o_d;

      // accept a change once stages two and three agree
      always_comb begin
        o_d = o_q;
        if (s2_q == s3_q) begin
          o_d = s3_q;
        end
      end

      // register the chain
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          o_q  <= 1'b0;
        end else begin
          s1_q <= din[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          o_q  <= o_d;
        end
      end

      assign dout[gi] = o_q;
    end
  endgenerate

endmodule // pbc_sync3

/* verification/pbc_loop_ctrl_tb.sv */
// self-checking bench for the loop bandwidth and multiplier control
`timescale 1ns/1ps
`include "pbc_consts.svh"

module pbc_loop_ctrl_tb;
  logic        mclk;                    // bus clock
  logic        sys_rst;                 // sync reset
  logic [1:0]  avs_address;             // word address
  logic        avs_read;                // read request
  logic        avs_write;               // write request
  logic [31:0] avs_writedata;           // write data
  logic [31:0] avs_readdata;            // read data
  logic        avs_waitrequest;         // stall
  logic        lock_raw;                // lock level
  logic        track_raw;               // tracking level
  logic        ref_active_raw;          // crystal activity
  logic        break_state;             // debug break
  logic        break_flag_clear_enable; // clear allowed in break
  logic        loop_irq_line;           // cpu request
  logic        loop_enable;             // loop on
  logic        base_clock_source_sel;   // vco select
  logic        auto_bw;                 // auto bandwidth
  logic        capture_phase_n;         // phase store
  logic [3:0]  feedback_n;              // divider modulus
  logic [3:0]  vco_range_sel;           // range field
  int          error_cnt;               // mismatches
  int          n_tests;                 // comparisons
  logic [31:0] exp_q[$];                // expected read data
  logic [31:0] rnd;                     // random write data

  pbc_loop_ctrl u_pbc_loop_ctrl (
    .mclk                    (mclk),
    .sys_rst                 (sys_rst),
    .avs_address             (avs_address),
    .avs_read                (avs_read),
    .avs_write               (avs_write),
    .avs_writedata           (avs_writedata),
    .avs_readdata            (avs_readdata),
    .avs_waitrequest         (avs_waitrequest),
    .lock_raw                (lock_raw),
    .track_raw               (track_raw),
    .ref_active_raw          (ref_active_raw),
    .break_state             (break_state),
    .break_flag_clear_enable (break_flag_clear_enable),
    .loop_irq_line           (loop_irq_line),
    .loop_enable             (loop_enable),
    .base_clock_source_sel   (base_clock_source_sel),
    .auto_bw                 (auto_bw),
    .capture_phase_n         (capture_phase_n),
    .feedback_n              (feedback_n),
    .vco_range_sel           (vco_range_sel)
  );

  // 200 mhz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // compare one value, count and report
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // print counts and verdict, end the run
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0 && exp_q.size() == 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(logic wr, logic [1:0] a, logic [7:0] d);
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_read      <= !wr;
    avs_write     <= wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(logic [1:0] a, logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  // read with its expected value noted first
  task automatic rd(logic [1:0] a, logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge mclk);
  endtask

  // watcher: each answered read takes the oldest note
  always @(posedge mclk) begin
    if (!sys_rst && avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        check("read without note", 32'h1, 32'h0);
      end else begin
        check("readdata", avs_readdata, exp_q.pop_front());
      end
    end
  end

  // watchdog cuts a hang short
  initial begin
    idle(20000);
    error_cnt++;
    conclude();
  end

  // main sequence
  initial begin
    error_cnt = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    avs_address = 2'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    lock_raw = 1'b0;
    track_raw = 1'b0;
    ref_active_raw = 1'b0;
    break_state = 1'b0;
    break_flag_clear_enable = 1'b0;
    rnd = $urandom(32'h5d15);
    idle(3);
    sys_rst <= 1'b0;
    idle(1);
    // reset values and unmapped place
    rd(`PBC_ADDR_CTRL, 8'h2f);
    rd(`PBC_ADDR_BW, 8'h00);
    rd(`PBC_ADDR_PROG, 8'h66);
    wr(2'h3, 8'hff);
    rd(2'h3, 8'h00);
    check("feedback_n", {28'h0, feedback_n}, 32'h6);
    check("loop_enable", {31'h0, loop_enable}, 32'h1);
    check("auto_bw", {31'h0, auto_bw}, 32'h0);
    // protected programming write while loop on
    rnd = $urandom;
    wr(`PBC_ADDR_PROG, rnd[7:0]);
    rd(`PBC_ADDR_PROG, 8'h66);
    // every multiplier code with the loop off
    wr(`PBC_ADDR_CTRL, 8'h00);
    for (int c = 0; c < 16; c++) begin
      wr(`PBC_ADDR_PROG, {c[3:0], 4'h6});
      check("feedback_n", {28'h0, feedback_n}, (c == 0) ? 32'h1 : c);
    end
    rd(`PBC_ADDR_PROG, 8'hf6);
    // zero range keeps the loop off and select clear
    wr(`PBC_ADDR_PROG, 8'h30);
    check("vco_range_sel", {28'h0, vco_range_sel}, 32'h0);
    wr(`PBC_ADDR_CTRL, 8'h20);
    check("loop_enable", {31'h0, loop_enable}, 32'h0);
    wr(`PBC_ADDR_CTRL, 8'h30);
    rd(`PBC_ADDR_CTRL, 8'h2f);
    // select needs two writes from off, unlocked allowed
    wr(`PBC_ADDR_CTRL, 8'h00);
    wr(`PBC_ADDR_PROG, 8'h36);
    check("vco_range_sel", {28'h0, vco_range_sel}, 32'h6);
    // phase cleared and test bits zero before the loop goes on
    wr(`PBC_ADDR_BW, 8'h00);
    wr(`PBC_ADDR_CTRL, 8'h30);
    rd(`PBC_ADDR_CTRL, 8'h2f);
    wr(`PBC_ADDR_CTRL, 8'h30);
    rd(`PBC_ADDR_CTRL, 8'h3f);
    check("select", {31'h0, base_clock_source_sel}, 32'h1);
    wr(`PBC_ADDR_CTRL, 8'h10);
    rd(`PBC_ADDR_CTRL, 8'h3f);
    // reference loss: inactive, then active, n is three
    wr(`PBC_ADDR_BW, 8'h10);
    idle(20);
    rd(`PBC_ADDR_BW, 8'h10);
    ref_active_raw <= 1'b1;
    idle(10);
    wr(`PBC_ADDR_BW, 8'h10);
    idle(20);
    rd(`PBC_ADDR_BW, 8'h00);
    // a pending loss result vanishes when the select drops
    ref_active_raw <= 1'b0;
    idle(10);
    wr(`PBC_ADDR_BW, 8'h10);
    rd(`PBC_ADDR_BW, 8'h10);
    wr(`PBC_ADDR_CTRL, 8'h20);
    rd(`PBC_ADDR_BW, 8'h00);
    wr(`PBC_ADDR_BW, 8'h10);
    idle(20);
    rd(`PBC_ADDR_BW, 8'h00);
    // capture phase manual, held across auto
    wr(`PBC_ADDR_BW, 8'h20);
    check("capture_phase_n", {31'h0, capture_phase_n}, 32'h1);
    wr(`PBC_ADDR_BW, 8'ha0);
    check("auto_bw", {31'h0, auto_bw}, 32'h1);
    rd(`PBC_ADDR_BW, 8'h80);
    track_raw <= 1'b1;
    idle(10);
    rd(`PBC_ADDR_BW, 8'ha0);
    track_raw <= 1'b0;
    wr(`PBC_ADDR_BW, 8'h80);
    wr(`PBC_ADDR_BW, 8'h00);
    rd(`PBC_ADDR_BW, 8'h20);
    // lock change sets flag with and without enable
    wr(`PBC_ADDR_BW, 8'h80);
    lock_raw <= 1'b1;
    idle(10);
    check("irq", {31'h0, loop_irq_line}, 32'h0);
    rd(`PBC_ADDR_BW, 8'hc0);
    rd(`PBC_ADDR_CTRL, 8'h6f);
    rd(`PBC_ADDR_CTRL, 8'h2f);
    wr(`PBC_ADDR_CTRL, 8'ha0);
    lock_raw <= 1'b0;
    idle(10);
    check("irq", {31'h0, loop_irq_line}, 32'h1);
    // after the request software looks at the lock bit
    rd(`PBC_ADDR_BW, 8'h80);
    // break: protected, then clear allowed
    break_state <= 1'b1;
    rd(`PBC_ADDR_CTRL, 8'hef);
    wr(`PBC_ADDR_CTRL, 8'ha0);
    rd(`PBC_ADDR_CTRL, 8'hef);
    break_flag_clear_enable <= 1'b1;
    rd(`PBC_ADDR_CTRL, 8'hef);
    break_state <= 1'b0;
    break_flag_clear_enable <= 1'b0;
    rd(`PBC_ADDR_CTRL, 8'haf);
    check("irq", {31'h0, loop_irq_line}, 32'h0);
    // manual mode hides flag and request
    lock_raw <= 1'b1;
    idle(10);
    wr(`PBC_ADDR_BW, 8'h00);
    idle(2);
    check("irq", {31'h0, loop_irq_line}, 32'h0);
    check("auto_bw", {31'h0, auto_bw}, 32'h0);
    rd(`PBC_ADDR_CTRL, 8'h2f);
    rd(`PBC_ADDR_BW, 8'h00);
    idle(2);
    conclude();
  end
endmodule // pbc_loop_ctrl_tb
